// ### src/vpd_log_responder.sv
// Command responder for vital data inquiry pages and log clearing.
// Assumes one AHB-Lite master, single word transfers, hready = hreadyout.
//
// Behaviour
// - Page 00h lists length 3 and codes 00h, 80h, 83h ascending.
// - Byte one of every vital page echoes the requested page code.
// - Byte zero carries qualifier zero and direct-access type zero.
// - Serial page has length 16 and ASCII serial in bytes 4 to 19.
// - Serial number is right aligned in its sixteen-byte field.
// - Identification page length 12, one descriptor with identifier length 8.
// - Descriptor code set is 1, meaning binary.
// - Descriptor association is 0h, the addressed device.
// - Descriptor identifier type is 03h.
// - 64-bit world wide identifier sits in bytes 8 to 15, MSB first.
// - Identifier is prefix, 12-bit block, 11b select, 22-bit serial.
// - Log clear is opcode 4Ch with reset, save, page control, list length.
// - Reset bit set clears log parameters; clear keeps them unless PC 11b.
// - Save bit set saves savable parameters after change; clear does not.
// - Page control 11b zeroes default cumulative values regardless of reset.
// - Page control 01b with reset bit zeroes current cumulative values.
// - Other page control values give check condition, invalid field.
// - List length must be zero; no pages are transferred.
// - Any wrong command block field gives check condition, invalid field; the code leaves reserved inquiry fields unchecked.
// - Log clearing returns the touched counters to zero; an event in the clearing cycle leaves them at one.
// - Changed parameters post unit attention to all other initiators.
// - Absent unit reports qualifier 011b and type 1Fh in byte zero.
// - Log clear to an absent unit ends in check condition.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`default_nettype none
module vpd_log_responder
  import vpd_log_pkg::*;
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // Statistics and attention.
  input  wire logic        stat_event,
  output var  logic [7:0]  unit_attention
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } state_e;

  state_e      state_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] cdb_w_r [3];
  logic [31:0] ser_w_r [4];
  logic [11:0] wwid_blk_r;
  logic [21:0] wwid_num_r;
  logic [2:0]  issuer_r;
  logic        lun_ok_r;
  logic [4:0]  slen_r;
  logic        done_r;
  logic        check_r;
  logic        saved_r;
  logic [3:0]  sense_key_r;
  logic [7:0]  asc_r;
  logic [7:0]  resp_len_r;
  logic [7:0]  resp_r [RESP_BYTES];
  logic [7:0]  ua_r;
  logic [31:0] cur_cnt_r;
  logic [31:0] dflt_cnt_r;
  logic [31:0] saved_cnt_r;

  // The slave never stalls and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign unit_attention = ua_r;

  // Address phase acceptance and data phase write strobes.
  wire       addr_ok  = hsel & hready & htrans[1];
  wire       busy     = state_r != ST_IDLE;
  wire       wr_cdb0  = wr_pend_r && wr_addr_r == OFF_CDB0;
  wire       wr_cdb1  = wr_pend_r && wr_addr_r == OFF_CDB1;
  wire       wr_cdb2  = wr_pend_r && wr_addr_r == OFF_CDB2;
  wire       wr_ctrl  = wr_pend_r && wr_addr_r == OFF_CTRL && !busy;
  wire       wr_wblk  = wr_pend_r && wr_addr_r == OFF_WWID_B;
  wire       wr_wnum  = wr_pend_r && wr_addr_r == OFF_WWID_N;
  wire       wr_ua    = wr_pend_r && wr_addr_r == OFF_UA;
  wire [7:0] ser_off  = wr_addr_r - OFF_SER0;
  wire       wr_ser   = wr_pend_r && ser_off < 8'd16;
  wire       go       = wr_ctrl && hwdata[CTRL_GO];

  // Command block bytes, byte zero in the low lane of the first word.
  logic [7:0] cdb [10];
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_cdb
      assign cdb[gi] = cdb_w_r[gi / 4][8 * (gi % 4) +: 8];
    end
  endgenerate

  // Command decode.
  wire        is_inq    = cdb[0] == OP_INQUIRY;
  wire        is_lc     = cdb[0] == OP_LOG_CLEAR;
  wire        vital_data_select = cdb[1][0];
  wire [7:0]  page_code = cdb[2];
  wire        pg_sup    = page_code == PAGE_SUP;
  wire        pg_ser    = page_code == PAGE_SER;
  wire        pg_idn    = page_code == PAGE_IDN;
  wire        inq_ok    = is_inq && vital_data_select &&
                          (pg_sup || pg_ser || pg_idn);
  wire        parameter_reset_bit = cdb[1][1];
  wire        save_parameters_bit = cdb[1][0];
  wire [1:0]  page_control_field  = cdb[2][7:6];
  wire [15:0] list_len  = {cdb[7], cdb[8]};
  wire        pc_ok     = page_control_field == PC_CURRENT ||
                          page_control_field == PC_DEFAULT;
  wire        rsv_ok    = cdb[1][7:2] == 6'h00 && cdb[2][5:0] == 6'h00 &&
                          {cdb[3], cdb[4], cdb[5], cdb[6]} == 32'h0 &&
                          cdb[9][7:2] == 6'h00;
  wire        lc_fields = pc_ok && rsv_ok && list_len == 16'h0;
  wire        lc_ok     = is_lc && lun_ok_r && lc_fields;
  wire        clr_cur   = lc_ok && parameter_reset_bit;
  wire        clr_dflt  = lc_ok &&
                          page_control_field == PC_DEFAULT;
  wire        changed   = clr_cur || clr_dflt;
  wire        cmd_ok    = inq_ok || lc_ok;
  wire [7:0]  asc_sel   = !(is_inq || is_lc) ? ASC_BAD_OP :
                          (is_lc && !lun_ok_r) ? ASC_NO_LUN :
                          ASC_BAD_FIELD;
  wire [7:0]  rlen_sel  = !inq_ok ? 8'h00 : pg_sup ? RLEN_SUP :
                          pg_ser ? RLEN_SER : RLEN_IDN;

  // Byte zero of the inquiry data depends on the unit being present.
  wire [7:0]  hdr0 = lun_ok_r ? {QUAL_OK, DTYPE_DISK}
                              : {QUAL_ABSENT, DTYPE_NONE};
  // World wide identifier, most significant field first.
  wire [63:0] wwid = {COMPANY_PREFIX, wwid_blk_r, PORT_NODE,
                      wwid_num_r};
  // Leading blank count that right aligns the serial characters.
  wire [4:0]  pad = SER_FULL - slen_r;

  // Serial characters as stored, first character in the low lane.
  logic [7:0] ser_byte [SER_BYTES];
  generate
    for (gi = 0; gi < SER_BYTES; gi++) begin : g_ser
      assign ser_byte[gi] = ser_w_r[gi / 4][8 * (gi % 4) +: 8];
    end
  endgenerate

  // Response bytes for each page, one lane per byte position.
  logic [7:0] page_b [RESP_BYTES];
  generate
    for (gi = 0; gi < RESP_BYTES; gi++) begin : g_page
      localparam int SL = (gi >= 4 && gi <= 6) ? 6 - gi : 0;
      localparam int SI = (gi >= 4) ? gi - 4 : 0;
      localparam int WB = (gi >= 8 && gi <= 15) ? 15 - gi : 0;
      localparam logic [4:0] SI5 = 5'(SI);
      wire [4:0] sidx  = SI5 - pad;
      wire [7:0] sup_b = (gi == 3) ? LEN_SUP :
                         (gi >= 4 && gi <= 6) ? SUP_LIST[SL * 8 +: 8] :
                         8'h00;
      wire [7:0] ser_b = (gi == 3) ? LEN_SER :
                         (gi < 4) ? 8'h00 :
                         (SI5 < pad) ? ASCII_SPACE :
                         ser_byte[sidx[3:0]];
      wire [7:0] idn_b = (gi == 3) ? LEN_IDN :
                         (gi == 4) ? {4'h0, CODE_SET_BIN} :
                         (gi == 5) ? {2'h0, ASSOC_DEV, ID_TYPE} :
                         (gi == 7) ? IDN_ID_LEN :
                         (gi >= 8 && gi <= 15) ? wwid[WB * 8 +: 8] :
                         8'h00;
      assign page_b[gi] = (gi == 0) ? hdr0 :
                          (gi == 1) ? page_code :
                          pg_sup ? sup_b : pg_ser ? ser_b : idn_b;
    end
  endgenerate

  // Counter next values; an event in the clearing cycle still counts.
  wire [31:0] ev     = {31'h0, stat_event};
  wire [31:0] cur_nxt  = (state_r == ST_EXEC && clr_cur ? 32'h0
                                                       : cur_cnt_r) + ev;
  wire [31:0] dflt_nxt = (state_r == ST_EXEC && clr_dflt ? 32'h0
                                                       : dflt_cnt_r) + ev;
  // Unit attention goes to everyone but the issuing initiator.
  wire [7:0]  ua_set  = (state_r == ST_EXEC && changed) ?
                        ~(8'h01 << issuer_r) : 8'h00;
  wire [7:0]  ua_clr  = wr_ua ? hwdata[7:0] : 8'h00;
  wire [7:0]  ua_nxt  = (ua_r & ~ua_clr) | ua_set;

  // Read decode; response words are read from a window of five words.
  wire [7:0]  rd_a    = haddr[7:0];
  wire [7:0]  rd_roff = rd_a - OFF_RESP0;
  wire [7:0]  rd_soff = rd_a - OFF_SER0;
  wire [2:0]  rd_ridx = rd_roff[4:2];
  logic [31:0] resp_word [RESP_WORDS];
  generate
    for (gi = 0; gi < RESP_WORDS; gi++) begin : g_rword
      assign resp_word[gi] = {resp_r[4 * gi + 3], resp_r[4 * gi + 2],
                              resp_r[4 * gi + 1], resp_r[4 * gi]};
    end
  endgenerate
  wire [31:0] ctrl_rd = {11'h0, slen_r, 7'h0, lun_ok_r, 1'b0, issuer_r,
                         4'h0};
  wire [31:0] stat_rd = {8'h0, resp_len_r, asc_r, sense_key_r, saved_r,
                         check_r, done_r, busy};
  wire [31:0] rd_word =
    (rd_a == OFF_CDB0)   ? cdb_w_r[0] :
    (rd_a == OFF_CDB1)   ? cdb_w_r[1] :
    (rd_a == OFF_CDB2)   ? {16'h0, cdb_w_r[2][15:0]} :
    (rd_a == OFF_CTRL)   ? ctrl_rd :
    (rd_a == OFF_STATUS) ? stat_rd :
    (rd_soff < 8'd16)    ? ser_w_r[rd_soff[3:2]] :
    (rd_a == OFF_WWID_B) ? {20'h0, wwid_blk_r} :
    (rd_a == OFF_WWID_N) ? {10'h0, wwid_num_r} :
    (rd_a == OFF_UA)     ? {24'h0, ua_r} :
    (rd_a == OFF_CUR)    ? cur_cnt_r :
    (rd_a == OFF_DFLT)   ? dflt_cnt_r :
    (rd_a == OFF_SAVED)  ? saved_cnt_r :
    (rd_roff < RESP_LIMIT) ? resp_word[rd_ridx] : 32'h0;

  // Bus pipeline: write address held for the data phase, read data latched.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_r <= haddr[7:0];
      if (addr_ok && !hwrite)
        hrdata_r <= rd_word;
    end
  end

  // Software-written configuration; command block is locked while busy.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int k = 0; k < 3; k++)
        cdb_w_r[k] <= 32'h0;
      for (int k = 0; k < 4; k++)
        ser_w_r[k] <= 32'h0;
      wwid_blk_r <= 12'h0;
      wwid_num_r <= 22'h0;
      issuer_r   <= 3'h0;
      lun_ok_r   <= 1'b1;
      slen_r     <= 5'h0;
    end
    else
    begin
      if (wr_cdb0 && !busy)
        cdb_w_r[0] <= hwdata;
      if (wr_cdb1 && !busy)
        cdb_w_r[1] <= hwdata;
      if (wr_cdb2 && !busy)
        cdb_w_r[2] <= {16'h0, hwdata[15:0]};
      if (wr_ser)
        ser_w_r[ser_off[3:2]] <= hwdata;
      if (wr_wblk)
        wwid_blk_r <= hwdata[11:0];
      if (wr_wnum)
        wwid_num_r <= hwdata[21:0];
      if (wr_ctrl)
      begin
        issuer_r <= hwdata[CTRL_ID +: 3];
        lun_ok_r <= hwdata[CTRL_LUN];
        slen_r   <= (hwdata[CTRL_SLEN +: 5] > SER_FULL) ? SER_FULL
                                                        : hwdata[CTRL_SLEN +: 5];
      end
    end
  end

  // Command sequencer: idle, one execute cycle, one completion cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= ST_IDLE;
    else
      unique case (state_r)
        ST_IDLE: state_r <= go ? ST_EXEC : ST_IDLE;
        ST_EXEC: state_r <= ST_DONE;
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
  end

  // Command results captured in the execute cycle; done flag set in the completion cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      done_r      <= 1'b0;
      check_r     <= 1'b0;
      saved_r     <= 1'b0;
      sense_key_r <= 4'h0;
      asc_r       <= 8'h00;
      resp_len_r  <= 8'h00;
      for (int k = 0; k < RESP_BYTES; k++)
        resp_r[k] <= 8'h00;
    end
    else if (state_r == ST_EXEC)
    begin
      check_r     <= !cmd_ok;
      sense_key_r <= cmd_ok ? 4'h0 : SK_ILLEGAL;
      asc_r       <= cmd_ok ? 8'h00 : asc_sel;
      saved_r     <= lc_ok && save_parameters_bit;
      resp_len_r  <= rlen_sel;
      if (inq_ok)
        for (int k = 0; k < RESP_BYTES; k++)
          resp_r[k] <= page_b[k];
    end
    else if (state_r == ST_DONE)
      done_r <= 1'b1;
    else if (go)
      done_r <= 1'b0;
  end

  // Statistics counters, saved copy and unit attention flags.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cur_cnt_r   <= 32'h0;
      dflt_cnt_r  <= 32'h0;
      saved_cnt_r <= 32'h0;
      ua_r        <= 8'h00;
    end
    else
    begin
      cur_cnt_r  <= cur_nxt;
      dflt_cnt_r <= dflt_nxt;
      ua_r       <= ua_nxt;
      if (state_r == ST_EXEC && lc_ok && save_parameters_bit)
        saved_cnt_r <= cur_nxt;
    end
  end

  // Checks on the finished command.
  wire exec_inq = state_r == ST_EXEC && inq_ok;
  wire exec_lc  = state_r == ST_EXEC && lc_ok;

  sequence s_go;
    state_r == ST_IDLE && go;
  endsequence
  sequence s_finish;
    state_r == ST_EXEC ##1 state_r == ST_DONE ##1 done_r;
  endsequence

  property p_cmd_flow;
    @(posedge hclk) disable iff (!hresetn)
    s_go |=> s_finish;
  endproperty
  a_cmd_flow: assert property (p_cmd_flow)
    else $error("command did not complete in three cycles");

  property p_sup_list;
    @(posedge hclk) disable iff (!hresetn)
    exec_inq && pg_sup |=> resp_r[3] == LEN_SUP && resp_r[4] == PAGE_SUP &&
      resp_r[5] == PAGE_SER && resp_r[6] == PAGE_IDN && resp_len_r == RLEN_SUP;
  endproperty
  a_sup_list: assert property (p_sup_list)
    else $error("supported page list wrong");

  property p_echo_hdr;
    @(posedge hclk) disable iff (!hresetn)
    exec_inq |=> resp_r[1] == $past(page_code) &&
      resp_r[0] == ($past(lun_ok_r) ? 8'h00 : 8'h7f);
  endproperty
  a_echo_hdr: assert property (p_echo_hdr)
    else $error("page header bytes wrong");

  property p_serial;
    @(posedge hclk) disable iff (!hresetn)
    exec_inq && pg_ser && slen_r < SER_FULL && slen_r != 5'h0 |=>
      resp_r[3] == LEN_SER && resp_r[4] == ASCII_SPACE &&
      resp_r[19] == $past(ser_byte[slen_r[3:0] - 4'h1]);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial page not right aligned");

  property p_ident;
    @(posedge hclk) disable iff (!hresetn)
    exec_inq && pg_idn |=> resp_r[3] == LEN_IDN && resp_r[7] == IDN_ID_LEN &&
      resp_r[4] == 8'h01 && resp_r[5] == 8'h03 && resp_len_r == RLEN_IDN;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identification descriptor wrong");

  property p_wwid;
    @(posedge hclk) disable iff (!hresetn)
    exec_inq && pg_idn |=> {resp_r[8], resp_r[9], resp_r[10], resp_r[11],
      resp_r[12], resp_r[13], resp_r[14], resp_r[15]} ==
      {COMPANY_PREFIX, $past(wwid_blk_r), 2'b11, $past(wwid_num_r)};
  endproperty
  a_wwid: assert property (p_wwid)
    else $error("world wide identifier wrong");

  property p_dflt_clear;
    @(posedge hclk) disable iff (!hresetn)
    exec_lc && page_control_field == PC_DEFAULT |=>
      dflt_cnt_r == {31'h0, $past(stat_event)};
  endproperty
  a_dflt_clear: assert property (p_dflt_clear)
    else $error("default values not cleared");

  property p_cur_keep;
    @(posedge hclk) disable iff (!hresetn)
    exec_lc && !parameter_reset_bit |=>
      cur_cnt_r == $past(cur_cnt_r) + {31'h0, $past(stat_event)};
  endproperty
  a_cur_keep: assert property (p_cur_keep)
    else $error("current values changed without reset bit");

  property p_bad_pc;
    @(posedge hclk) disable iff (!hresetn)
    state_r == ST_EXEC && is_lc && lun_ok_r && !pc_ok |=>
      check_r && sense_key_r == SK_ILLEGAL && asc_r == ASC_BAD_FIELD
      ##2 done_r && check_r;
  endproperty
  a_bad_pc: assert property (p_bad_pc)
    else $error("bad page control not refused");

  property p_ua_post;
    @(posedge hclk) disable iff (!hresetn)
    exec_lc && changed |=>
      (ua_r | (8'h01 << $past(issuer_r))) == 8'hff;
  endproperty
  a_ua_post: assert property (p_ua_post)
    else $error("unit attention not posted");

  property p_save;
    @(posedge hclk) disable iff (!hresetn)
    exec_lc && save_parameters_bit |=> saved_cnt_r == cur_cnt_r && saved_r;
  endproperty
  a_save: assert property (p_save)
    else $error("parameters not saved");
endmodule // vpd_log_responder
`default_nettype wire

// ### src/vpd_log_pkg.sv
// Constants for the vital data inquiry and log clearing responder.
// Assumes a 32-bit AHB-Lite slave port and byte-wide command blocks.
`default_nettype none
package vpd_log_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CDB0   = 8'h00;
  localparam logic [7:0] OFF_CDB1   = 8'h04;
  localparam logic [7:0] OFF_CDB2   = 8'h08;
  localparam logic [7:0] OFF_CTRL   = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_SER0   = 8'h20;
  localparam logic [7:0] OFF_WWID_B = 8'h30;
  localparam logic [7:0] OFF_WWID_N = 8'h34;
  localparam logic [7:0] OFF_UA     = 8'h38;
  localparam logic [7:0] OFF_CUR    = 8'h3c;
  localparam logic [7:0] OFF_DFLT   = 8'h40;
  localparam logic [7:0] OFF_SAVED  = 8'h44;
  localparam logic [7:0] OFF_RESP0  = 8'h60;
  // Control and status field positions.
  localparam int CTRL_GO    = 0;
  localparam int CTRL_ID    = 4;
  localparam int CTRL_LUN   = 8;
  localparam int CTRL_SLEN  = 16;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_CHECK = 2;
  localparam int STAT_SAVED = 3;
  localparam int STAT_SK    = 4;
  localparam int STAT_ASC   = 8;
  localparam int STAT_LEN   = 16;
  // Sizes.
  localparam int RESP_BYTES = 20;
  localparam int RESP_WORDS = 5;
  localparam int SER_BYTES  = 16;
  localparam int NUM_INIT   = 8;
  localparam logic [7:0] RESP_LIMIT = 8'd20;
  localparam logic [4:0] SER_FULL   = 5'd16;
  // Command codes, pages and fixed page fields.
  localparam logic [7:0] OP_INQUIRY   = 8'h12;
  localparam logic [7:0] OP_LOG_CLEAR = 8'h4c;
  localparam logic [7:0] PAGE_SUP     = 8'h00;
  localparam logic [7:0] PAGE_SER     = 8'h80;
  localparam logic [7:0] PAGE_IDN     = 8'h83;
  localparam logic [23:0] SUP_LIST    = 24'h008083;
  localparam logic [7:0] LEN_SUP      = 8'h03;
  localparam logic [7:0] LEN_SER      = 8'h10;
  localparam logic [7:0] LEN_IDN      = 8'h0c;
  localparam logic [7:0] IDN_ID_LEN   = 8'h08;
  localparam logic [3:0] CODE_SET_BIN = 4'h1;
  localparam logic [1:0] ASSOC_DEV    = 2'h0;
  localparam logic [3:0] ID_TYPE      = 4'h3;
  localparam logic [1:0] PORT_NODE    = 2'h3;
  localparam logic [2:0] QUAL_OK      = 3'h0;
  localparam logic [2:0] QUAL_ABSENT  = 3'h3;
  localparam logic [4:0] DTYPE_DISK   = 5'h00;
  localparam logic [4:0] DTYPE_NONE   = 5'h1f;
  localparam logic [7:0] ASCII_SPACE  = 8'h20;
  localparam logic [7:0] RLEN_SUP     = 8'd7;
  localparam logic [7:0] RLEN_SER     = 8'd20;
  localparam logic [7:0] RLEN_IDN     = 8'd16;
  // Page control values and sense data.
  localparam logic [1:0] PC_CURRENT   = 2'h1;
  localparam logic [1:0] PC_DEFAULT   = 2'h3;
  localparam logic [3:0] SK_ILLEGAL   = 4'h5;
  localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
  localparam logic [7:0] ASC_BAD_OP    = 8'h20;
  localparam logic [7:0] ASC_NO_LUN    = 8'h25;
  // Company prefix of the world wide identifier; value is arbitrary.
  localparam logic [27:0] COMPANY_PREFIX = 28'h0a5a5a5;
endpackage
`default_nettype wire

// ### verif/scsi_host_model.sv
// Host adapter model: AHB-Lite master that loads and runs command blocks.
// Assumes hready is the responder's hreadyout and tasks start at an edge.
`default_nettype none
module scsi_host_model
(
  // Bus clock.
  input  wire logic        hclk,
  // AHB-Lite master side.
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  import vpd_log_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // The bus rests idle until the first transfer.
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
  end
  // One single word transfer; write data is scrambled once released.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask
  // Loads a command block, starts it and polls status until it is done, at most 40 reads.
  task automatic issue(input logic [31:0] c0, c1, c2, ctrl,
                       output logic [31:0] st);
    logic [31:0] q;
    int n;
    xfer(1'b1, OFF_CDB0, c0, q);
    xfer(1'b1, OFF_CDB1, c1, q);
    xfer(1'b1, OFF_CDB2, c2, q);
    xfer(1'b1, OFF_CTRL, ctrl | 32'h1, q);
    n = 0;
    st = 32'h0;
    while (st[STAT_DONE] !== 1'b1 && n < 40)
    begin
      xfer(1'b0, OFF_STATUS, 32'h0, st);
      n++;
    end
  endtask
endmodule // scsi_host_model
`default_nettype wire

// ### verif/vpd_log_responder_bench.sv
// Self-checking bench for the vital data and log clearing responder.
// Assumes the host model owns the bus and the bench drives stat_event.
`default_nettype none
module vpd_log_responder_bench;
  import vpd_log_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, stat_event;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q, st;
  logic [7:0]  unit_attention;
  logic [63:0] wwid;
  int          errors, compares, cycles;
  // Refused log clear blocks: PC 00b, PC 10b, reserved bit, length, lun.
  logic [31:0] tc0 [5] = '{32'h14c, 32'h80014c, 32'h40054c, 32'h40014c,
                           32'h40014c};
  logic [31:0] tc2 [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
  logic [31:0] tct [5] = '{32'h121, 32'h121, 32'h121, 32'h121, 32'h21};
  logic [7:0]  tas [5] = '{8'h24, 8'h24, 8'h24, 8'h24, 8'h25};
  always #4 hclk = ~hclk;
  // Design under test and the host that drives its bus.
  vpd_log_responder uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .stat_event(stat_event),
    .unit_attention(unit_attention));
  scsi_host_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  task automatic end_sim;
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic inq(input logic [7:0] pg, input logic [31:0] ctrl);
    host.issue({8'h0, pg, 8'h01, 8'h12}, 32'hff, 32'h0, ctrl, st);
  endtask
  // Good status, then response bytes held MSB first in v.
  task automatic resp(input logic [159:0] v, input logic [7:0] len);
    `CHK(st & 32'h00fffff7, {8'h0, len, 16'h0002})
    for (int i = 0; i < len; i++)
    begin
      if (i % 4 == 0) host.xfer(1'b0, OFF_RESP0 + 8'(i), 32'h0, q);
      `CHK(q[8*(i%4) +: 8], v[159-8*i -: 8])
    end
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      stat_event <= 1'b1;
      @(posedge hclk);
      stat_event <= 1'b0;
      @(posedge hclk);
    end
  endtask
  // A hang is cut short by a cycle ceiling.
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      end_sim;
    end
  end
  // Main sequence.
  initial
  begin
    hresetn = 1'b0;
    stat_event = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(8'h50, 32'h0);
    rd_chk(OFF_CTRL, 32'h100);
    inq(8'h00, 32'h100);
    resp({56'h00000003008083, 104'h0}, 8'd7);
    host.xfer(1'b1, OFF_SER0, 32'h00434241, q);
    inq(8'h80, 32'h30100);
    resp({32'h00800010, {13{8'h20}}, 24'h414243}, 8'd20);
    wwid = {COMPANY_PREFIX, 12'habc, 2'b11, 22'h2aaaaa};
    host.xfer(1'b1, OFF_WWID_B, 32'habc, q);
    host.xfer(1'b1, OFF_WWID_N, 32'h2aaaaa, q);
    inq(8'h83, 32'h100);
    resp({64'h0083000c01030008, wwid, 32'h0}, 8'd16);
    inq(8'h00, 32'h0);
    resp({56'h7f000003008083, 104'h0}, 8'd7);
    inq(8'h81, 32'h100);
    `CHK(st & 32'h00fffff7, 32'h2456)
    host.issue(32'h4d, 32'h0, 32'h0, 32'h100, st);
    `CHK(st & 32'h00fffff7, 32'h2056)
    pulse(5);
    host.issue(32'hc0014c, 32'h0, 32'h0, 32'h151, st);
    `CHK(st & 32'h00fffff7, 32'h2)
    rd_chk(OFF_DFLT, 32'h0);
    rd_chk(OFF_CUR, 32'h5);
    rd_chk(OFF_SAVED, 32'h5);
    `CHK(unit_attention, 8'hdf)
    host.xfer(1'b1, OFF_UA, 32'hff, q);
    pulse(2);
    host.issue(32'h40024c, 32'h0, 32'h0, 32'h121, st);
    `CHK(st & 32'h00fffff7, 32'h2)
    rd_chk(OFF_CUR, 32'h0);
    rd_chk(OFF_DFLT, 32'h2);
    rd_chk(OFF_SAVED, 32'h5);
    rd_chk(OFF_UA, 32'hfb);
    host.xfer(1'b1, OFF_UA, 32'hff, q);
    pulse(3);
    for (int k = 0; k < 5; k++)
    begin
      host.issue(tc0[k], 32'h0, tc2[k], tct[k], st);
      `CHK(st & 32'h00fffff7, {16'h0, tas[k], 8'h56})
    end
    rd_chk(OFF_CUR, 32'h3);
    `CHK(unit_attention, 8'h00)
    `CHK({hreadyout, hresp}, 2'b10)
    end_sim;
  end
endmodule // vpd_log_responder_bench
`default_nettype wire
